// [pkg/jtd_regs.vh]
// Constants of the emulation test access port: opcodes, widths and reset values
`ifndef JTD_REGS_VH
`define JTD_REGS_VH

`define JTD_IR_W 8
`define JTD_IR_RESET 8'hFF
`define JTD_IR_CAPTURE 8'h01

`define JTD_OP_EXTEST 8'h00
`define JTD_OP_SAMPLE 8'h02
`define JTD_OP_PRIVATE_A 8'h03
`define JTD_OP_HIGHZ 8'h06
`define JTD_OP_PRIVATE_B 8'h20
`define JTD_OP_PRIVATE_K 8'h29
`define JTD_OP_BYPASS 8'hFF

`define JTD_CLASS_W 3
`define JTD_CLASS_BYPASS 3'h0
`define JTD_CLASS_EXTEST 3'h1
`define JTD_CLASS_SAMPLE 3'h2
`define JTD_CLASS_HIGHZ 3'h3
`define JTD_CLASS_PRIVATE 3'h4
`define JTD_CLASS_UNKNOWN 3'h5

`define JTD_SYNC_STAGES 2

`endif

// [core/jtd_tap.v]
// Emulation test access port with a single dummy boundary cell, sampled on the core clock
//
// How it works
// - The instruction register is eight bits long and shifts eight bits per instruction load.
// - The boundary path is one dummy cell between scan input and scan output, for loopback only.
// - Sample 00000010 and high-impedance 00000110 are valid codes with no functional effect.
// - High-impedance touches only the dummy cell and leaves every pin driving normally.
// - Bypass 11111111, external test and eleven private codes 00000011, 00100000-00101001 decode.
// - Both emulation pins are open-collector outputs, wire-ORed and pulled high outside.
`include "jtd_regs.vh"

module jtd_tap (
  input wire core_clk,
  input wire rst,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output reg tdo,
  output reg tdo_oe_n,
  input wire emulation_ctrl_pin_a_i,
  output reg emulation_ctrl_pin_a_o,
  output reg emulation_ctrl_pin_a_oe_n,
  input wire emulation_ctrl_pin_b_i,
  output reg emulation_ctrl_pin_b_o,
  output reg emulation_ctrl_pin_b_oe_n,
  input wire emu_a_pull,
  input wire emu_b_pull,
  output reg emu_a_level,
  output reg emu_b_level,
  output reg [`JTD_IR_W-1:0] active_opcode,
  output reg [`JTD_CLASS_W-1:0] active_class,
  output reg [15:0] tap_state,
  output reg ir_update_pulse,
  output reg private_active
);

  localparam [15:0] ST_RESET = 16'h0001;
  localparam [15:0] ST_IDLE = 16'h0002;
  localparam [15:0] ST_SEL_DR = 16'h0004;
  localparam [15:0] ST_CAP_DR = 16'h0008;
  localparam [15:0] ST_SHIFT_DR = 16'h0010;
  localparam [15:0] ST_EXIT1_DR = 16'h0020;
  localparam [15:0] ST_PAUSE_DR = 16'h0040;
  localparam [15:0] ST_EXIT2_DR = 16'h0080;
  localparam [15:0] ST_UPD_DR = 16'h0100;
  localparam [15:0] ST_SEL_IR = 16'h0200;
  localparam [15:0] ST_CAP_IR = 16'h0400;
  localparam [15:0] ST_SHIFT_IR = 16'h0800;
  localparam [15:0] ST_EXIT1_IR = 16'h1000;
  localparam [15:0] ST_PAUSE_IR = 16'h2000;
  localparam [15:0] ST_EXIT2_IR = 16'h4000;
  localparam [15:0] ST_UPD_IR = 16'h8000;

  // Step of the standard controller for one rising test-clock edge
  function [15:0] next_state;
    input [15:0] cur;
    input mode;
    begin
      case (cur)
        ST_RESET: next_state = mode ? ST_RESET : ST_IDLE;
        ST_IDLE: next_state = mode ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: next_state = mode ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: next_state = mode ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: next_state = mode ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: next_state = mode ? ST_UPD_DR : ST_PAUSE_DR;
        ST_PAUSE_DR: next_state = mode ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: next_state = mode ? ST_UPD_DR : ST_SHIFT_DR;
        ST_UPD_DR: next_state = mode ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: next_state = mode ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: next_state = mode ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: next_state = mode ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: next_state = mode ? ST_UPD_IR : ST_PAUSE_IR;
        ST_PAUSE_IR: next_state = mode ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: next_state = mode ? ST_UPD_IR : ST_SHIFT_IR;
        ST_UPD_IR: next_state = mode ? ST_SEL_DR : ST_IDLE;
        default: next_state = ST_RESET;
      endcase
    end
  endfunction

  // Opcode classes; codes outside the table fall back to bypass behaviour
  function [`JTD_CLASS_W-1:0] classify;
    input [`JTD_IR_W-1:0] op;
    begin
      if (op == `JTD_OP_BYPASS)
        classify = `JTD_CLASS_BYPASS;
      else if (op == `JTD_OP_EXTEST)
        classify = `JTD_CLASS_EXTEST;
      else if (op == `JTD_OP_SAMPLE)
        classify = `JTD_CLASS_SAMPLE;
      else if (op == `JTD_OP_HIGHZ)
        classify = `JTD_CLASS_HIGHZ;
      else if (op == `JTD_OP_PRIVATE_A ||
               (op >= `JTD_OP_PRIVATE_B && op <= `JTD_OP_PRIVATE_K))
        classify = `JTD_CLASS_PRIVATE;
      else
        classify = `JTD_CLASS_UNKNOWN;
    end
  endfunction

  // Two-flop synchronisers; stage one is read only by stage two
  reg tck_s1_r, tck_s2_r, tck_s3_r;
  reg tms_s1_r, tms_s2_r;
  reg tdi_s1_r, tdi_s2_r;
  reg trst_s1_r, trst_s2_r;
  reg emu_a_s1_r, emu_b_s1_r;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_s3_r <= 1'b0;
      tms_s1_r <= 1'b1;
      tms_s2_r <= 1'b1;
      tdi_s1_r <= 1'b0;
      tdi_s2_r <= 1'b0;
      trst_s1_r <= 1'b0;
      trst_s2_r <= 1'b0;
      emu_a_s1_r <= 1'b1;
      emu_b_s1_r <= 1'b1;
      emu_a_level <= 1'b1;
      emu_b_level <= 1'b1;
    end
    else
    begin
      tck_s1_r <= tck;
      tck_s2_r <= tck_s1_r;
      tck_s3_r <= tck_s2_r;
      tms_s1_r <= tms;
      tms_s2_r <= tms_s1_r;
      tdi_s1_r <= tdi;
      tdi_s2_r <= tdi_s1_r;
      trst_s1_r <= trst_n;
      trst_s2_r <= trst_s1_r;
      emu_a_s1_r <= emulation_ctrl_pin_a_i;
      emu_a_level <= emu_a_s1_r;
      emu_b_s1_r <= emulation_ctrl_pin_b_i;
      emu_b_level <= emu_b_s1_r;
    end
  end

  // Mode and data travel through the same depth as the clock, so they stay aligned
  wire tck_rise = tck_s2_r & ~tck_s3_r;
  wire tck_fall = ~tck_s2_r & tck_s3_r;
  wire trst_act = ~trst_s2_r;

  reg [`JTD_IR_W-1:0] ir_shift_r;
  reg bypass_r;
  reg dummy_cell_r;

  wire in_shift_ir = (tap_state == ST_SHIFT_IR);
  wire in_shift_dr = (tap_state == ST_SHIFT_DR);
  wire sel_bypass = (active_class == `JTD_CLASS_BYPASS) ||
                    (active_class == `JTD_CLASS_UNKNOWN);

  // Controller and scan registers, all stepping on the rising test-clock edge
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tap_state <= ST_RESET;
      ir_shift_r <= `JTD_IR_RESET;
      active_opcode <= `JTD_IR_RESET;
      active_class <= `JTD_CLASS_BYPASS;
      bypass_r <= 1'b0;
      dummy_cell_r <= 1'b0;
      ir_update_pulse <= 1'b0;
      private_active <= 1'b0;
    end
    else if (trst_act)
    begin
      tap_state <= ST_RESET;
      active_opcode <= `JTD_IR_RESET;
      active_class <= `JTD_CLASS_BYPASS;
      ir_update_pulse <= 1'b0;
      private_active <= 1'b0;
    end
    else
    begin
      ir_update_pulse <= 1'b0;
      if (tck_rise)
      begin
        tap_state <= next_state(tap_state, tms_s2_r);
        case (tap_state)
          ST_RESET:
          begin
            active_opcode <= `JTD_IR_RESET;
            active_class <= `JTD_CLASS_BYPASS;
            private_active <= 1'b0;
          end
          ST_CAP_IR:
            ir_shift_r <= `JTD_IR_CAPTURE;
          ST_SHIFT_IR:
            ir_shift_r <= {tdi_s2_r, ir_shift_r[`JTD_IR_W-1:1]};
          ST_UPD_IR:
          begin
            active_opcode <= ir_shift_r;
            active_class <= classify(ir_shift_r);
            // Private codes are only flagged; their effect belongs to the core
            private_active <= (classify(ir_shift_r) == `JTD_CLASS_PRIVATE);
            ir_update_pulse <= 1'b1;
          end
          ST_CAP_DR:
          begin
            bypass_r <= 1'b0;
            // The dummy cell keeps its value: capture reads nothing from pins
          end
          ST_SHIFT_DR:
          begin
            if (sel_bypass)
              bypass_r <= tdi_s2_r;
            else
              dummy_cell_r <= tdi_s2_r;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Output changes on the falling edge so the controller samples a settled bit
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end
    else if (trst_act)
    begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end
    else if (tck_fall)
    begin
      if (in_shift_ir)
      begin
        tdo <= ir_shift_r[0];
        tdo_oe_n <= 1'b0;
      end
      else if (in_shift_dr)
      begin
        tdo <= sel_bypass ? bypass_r : dummy_cell_r;
        tdo_oe_n <= 1'b0;
      end
      else
        tdo_oe_n <= 1'b1;
    end
  end

  // Open-collector emulation pins: only ever pull low, never drive high
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      emulation_ctrl_pin_a_o <= 1'b0;
      emulation_ctrl_pin_a_oe_n <= 1'b1;
      emulation_ctrl_pin_b_o <= 1'b0;
      emulation_ctrl_pin_b_oe_n <= 1'b1;
    end
    else
    begin
      emulation_ctrl_pin_a_o <= 1'b0;
      emulation_ctrl_pin_a_oe_n <= ~emu_a_pull;
      emulation_ctrl_pin_b_o <= 1'b0;
      emulation_ctrl_pin_b_oe_n <= ~emu_b_pull;
    end
  end

  // High-impedance opcode drives no pin enable here: device pins stay driving

endmodule

// [testbench/jtd_tap_monitor.sv]
// Checker of the emulation test port outputs
module jtd_tap_monitor (
  input wire core_clk,
  input wire rst,
  input wire tck,
  input wire trst_n,
  input wire tdo,
  input wire tdo_oe_n,
  input wire emulation_ctrl_pin_a_o,
  input wire emulation_ctrl_pin_a_oe_n,
  input wire emu_a_pull,
  input wire [7:0] active_opcode,
  input wire [2:0] active_class,
  input wire [15:0] tap_state,
  input wire ir_update_pulse,
  input wire private_active
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [7:0] op = active_opcode;
  wire prv = op == 8'h03 || (op >= 8'h20 && op <= 8'h29);
  wire [2:0] cls = op == 8'hFF ? 3'h0 : op == 8'h00 ? 3'h1 : op == 8'h02 ? 3'h2 :
    op == 8'h06 ? 3'h3 : prv ? 3'h4 : 3'h5;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_hot; $onehot(tap_state); endproperty
  a_hot: assert property (p_hot) else $error("state not one-hot");
  property p_trst; !trst_n [*5] |-> tap_state == 16'h0001 && op == 8'hFF; endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");
  property p_dec; active_class == cls && private_active == prv; endproperty
  a_dec: assert property (p_dec) else $error("opcode class wrong");
  property p_load; $changed(op) |-> ir_update_pulse || op == 8'hFF; endproperty
  a_load: assert property (p_load) else $error("opcode moved off update");
  property p_pls; ir_update_pulse |=> !ir_update_pulse; endproperty
  a_pls: assert property (p_pls) else $error("update pulse too long");
  // Shift and exit1 of either path: exit1 keeps the driver until the next fall
  property p_oe; !tdo_oe_n |-> (tap_state & 16'h1830) != 16'h0000; endproperty
  a_oe: assert property (p_oe) else $error("tdo driven off shift");
  property p_tdo; $changed(tdo) |-> !tck; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved with tck high");
  property p_emu; emulation_ctrl_pin_a_oe_n == !$past(emu_a_pull) && !emulation_ctrl_pin_a_o;
  endproperty
  a_emu: assert property (p_emu) else $error("emulation pin a wrong");
  c_hz: cover property (ir_update_pulse && active_class == 3'h3);
  c_prv: cover property (private_active);
  c_emu: cover property (!emulation_ctrl_pin_a_oe_n);
endmodule
bind jtd_tap jtd_tap_monitor u_jtd_tap_monitor (
  .core_clk(core_clk), .rst(rst), .tck(tck), .trst_n(trst_n), .tdo(tdo),
  .tdo_oe_n(tdo_oe_n), .emulation_ctrl_pin_a_o(emulation_ctrl_pin_a_o),
  .emulation_ctrl_pin_a_oe_n(emulation_ctrl_pin_a_oe_n), .emu_a_pull(emu_a_pull),
  .active_opcode(active_opcode), .active_class(active_class), .tap_state(tap_state),
  .ir_update_pulse(ir_update_pulse), .private_active(private_active)
);

// [testbench/jtd_ctl.sv]
// Model of the emulation controller that drives the test link
module jtd_ctl (
  input wire core_clk,
  input wire tdo,
  output logic tck = 1'b0,
  output logic tms = 1'b1,
  output logic tdi = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // 25 ns setup, 75 ns high, 100 ns low; tck rests low between frames
  task automatic step(input logic m, input logic d, output logic q);
    q = tdo;
    tms = m;
    tdi = d;
    @(posedge core_clk);
    #1 tck = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 tck = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  // Private codes go out only when a test asks for them
  task automatic scan(input logic to_ir, input logic [7:0] d, output logic [7:0] q);
    logic b;
    step(1'b0, 1'b0, b);
    step(1'b1, 1'b0, b);
    if (to_ir)
      step(1'b1, 1'b0, b);
    repeat (2) step(1'b0, 1'b0, b);
    for (int i = 0; i < 8; i++)
    begin
      step(i == 7, d[i], b);
      q[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule

// [testbench/jtd_tap_tb.sv]
// Self-checking bench of the emulation test port
module jtd_tap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic trst_n = 1'b1;
  logic emu_a_pull = 1'b0;
  logic emu_b_pull = 1'b0;
  logic ext_b = 1'b0;
  wire tck, tms, tdi, tdo, tdo_oe_n, ao, aoe, bo, boe, al, bl, pls, prv;
  wire [7:0] opc;
  wire [2:0] cls;
  wire [15:0] st;
  // Pulled-up lines: any party pulling wins
  wire tdo_w = tdo_oe_n ? 1'b1 : tdo;
  wire line_a = aoe ? 1'b1 : ao;
  wire line_b = (boe ? 1'b1 : bo) & !ext_b;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  jtd_tap u_jtd_tap (
    .core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .emulation_ctrl_pin_a_i(line_a),
    .emulation_ctrl_pin_a_o(ao), .emulation_ctrl_pin_a_oe_n(aoe),
    .emulation_ctrl_pin_b_i(line_b), .emulation_ctrl_pin_b_o(bo),
    .emulation_ctrl_pin_b_oe_n(boe), .emu_a_pull(emu_a_pull), .emu_b_pull(emu_b_pull),
    .emu_a_level(al), .emu_b_level(bl), .active_opcode(opc), .active_class(cls),
    .tap_state(st), .ir_update_pulse(pls), .private_active(prv)
  );
  jtd_ctl u_jtd_ctl (.core_clk(core_clk), .tdo(tdo_w), .tck(tck), .tms(tms), .tdi(tdi));
  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_errors++;
      wrap_up;
    end
  end
  // Wide enough for state and opcode together, so no state bit is dropped
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic t_codes;
    logic [7:0] ops [6] = '{8'h00, 8'h02, 8'h06, 8'h03, 8'h55, 8'hFF};
    logic [2:0] cl [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
    logic [7:0] op, q;
    for (int i = 0; i < 16; i++)
    begin
      op = i < 6 ? ops[i] : 8'h1A + 8'(i);
      u_jtd_ctl.scan(1'b1, op, q);
      chk("capture", 8'h01, q);
      chk("opcode", op, opc);
      chk("class", i < 6 ? cl[i] : 3'h4, cls);
      chk("private", i == 3 || i > 5, prv);
      chk("state", 16'h0002, st);
    end
  endtask
  task automatic t_loop;
    logic [7:0] q;
    u_jtd_ctl.scan(1'b1, 8'hFF, q);
    u_jtd_ctl.scan(1'b0, 8'h96, q);
    chk("bypass", 8'h2C, q);
    u_jtd_ctl.scan(1'b1, 8'h06, q);
    u_jtd_ctl.scan(1'b0, 8'hA5, q);
    chk("dummy", 7'h25, q[7:1]);
    u_jtd_ctl.scan(1'b0, 8'h3C, q);
    chk("dummy kept", 8'h79, q);
  endtask
  // Runs under the high-impedance code: pins must still drive
  task automatic t_emu;
    chk("opcode hz", 8'h06, opc);
    emu_a_pull = 1'b1;
    ext_b = 1'b1;
    wait_c(4);
    chk("pin a", 2'b00, {aoe, al});
    chk("pin b", 2'b10, {boe, bl});
    emu_a_pull = 1'b0;
    ext_b = 1'b0;
    emu_b_pull = 1'b1;
    wait_c(4);
    chk("pin b pull", 3'b000, {boe, bo, bl});
    chk("pin a free", 2'b11, {aoe, al});
    emu_b_pull = 1'b0;
    wait_c(4);
    chk("levels", 2'b11, {al, bl});
  endtask
  task automatic t_trst;
    logic [7:0] q;
    logic b;
    // Held long enough that the checker sees five low samples
    trst_n = 1'b0;
    wait_c(6);
    chk("trst", 24'h0001FF, {st, opc});
    trst_n = 1'b1;
    wait_c(3);
    u_jtd_ctl.scan(1'b1, 8'h02, q);
    repeat (5) u_jtd_ctl.step(1'b1, 1'b0, b);
    chk("tms reset", 24'h0001FF, {st, opc});
  endtask
  initial
  begin
    wait_c(6);
    rst = 1'b0;
    wait_c(4);
    chk("reset", 24'h0001FF, {st, opc});
    chk("reset pins", 3'b111, {tdo_oe_n, aoe, boe});
    t_codes;
    t_loop;
    t_emu;
    t_trst;
    wrap_up;
  end
endmodule
